// file: verilog/spm_defs.svh
// Constants for the self-programming flash controller.
// Assumes a 40 MHz system clock and AXI4-Lite register access.
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
`define CLK_PERIOD_NS   25
`define PROG_TIME_NS    3700000
`define ADDR_W          8
`define OFF_CTRL        8'h00
`define OFF_LOCK        8'h04
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define BIT_INT_EN      7
`define BIT_BUSY        6
`define BIT_RSVD        5
`define CMD_REEN        5'h11
`define CMD_LOCK        5'h09
`define CMD_PGWR        5'h05
`define CMD_PGER        5'h03
`define CMD_LOAD        5'h01
`define ARM_CYCLES      3'h4
`define LPM_CYCLES      3'h3
`define WORD_LSB        1
`define WORD_W          6
`define PAGE_LSB        7
`define PAGE_W          9
`define HALTING_WRITE_SECTION_FIRST_PAGE 9'h1C0
`define LOCK_RESET      8'hFF
`define TIMER_W         24
`define ERASED_WORD     16'hFFFF
`endif

// file: verilog/spm_pkg.sv
// Types shared by the self-programming flash controller files.
// Assumes spm_defs.svh is on the include path.
`include "spm_defs.svh"
package spm_pkg;
   typedef struct packed {
      logic        spm;
      logic        load_program_instruction;
      logic [15:0] z;
      logic [7:0]  r0;
      logic [7:0]  r1;
   } cpu_req_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } lpm_rsp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} op_state_t;
endpackage

// file: verilog/page_buffer_mem.sv
// Temporary page buffer: one word per page slot, registered read port.
// Assumes the clear and write never target the same cycle on purpose.
`timescale 1ns/1ps
`include "spm_defs.svh"
module page_buffer_mem (
   input  wire logic                 clk_in,
   input  wire logic                 resetn_in,
   input  wire logic                 clear_in,
   input  wire logic                 we_in,
   input  wire logic [`WORD_W-1:0]   waddr_in,
   input  wire logic [15:0]          wdata_in,
   input  wire logic [`WORD_W-1:0]   raddr_in,
   output logic      [15:0]          rdata_out
);
   logic [15:0] mem_q [0:(1<<`WORD_W)-1];

   // Clear wins over a write so an abort leaves nothing behind
   for (genvar i = 0; i < (1<<`WORD_W); i++) begin : g_word
      always_ff @(posedge clk_in) begin
         if (!resetn_in || clear_in) begin
            mem_q[i] <= `ERASED_WORD;
         end else if (we_in && waddr_in == `WORD_W'(i)) begin
            mem_q[i] <= wdata_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         rdata_out <= `ERASED_WORD;
      end else begin
         rdata_out <= mem_q[raddr_in];
      end
   end
endmodule

// file: verilog/prog_timer.sv
// Programming-time counter; one done pulse after the loaded count.
// Assumes start is not raised again while running.
`timescale 1ns/1ps
`include "spm_defs.svh"
module prog_timer (
   input  wire logic                clk_in,
   input  wire logic                resetn_in,
   input  wire logic                start_in,
   input  wire logic [`TIMER_W-1:0] count_in,
   output logic                     done_out
);
   logic [`TIMER_W-1:0] cnt_q;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cnt_q    <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= (cnt_q == `TIMER_W'(1));
         if (start_in) begin
            cnt_q <= count_in;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - `TIMER_W'(1);
         end
      end
   end
endmodule

// file: verilog/self_programming_flash_control.sv
// Self-programming flash controller: control register, arming window,
// page buffer fill, page erase/write, lock set and fuse/lock readback.
// Assumes the CPU strobes store/load for one cycle with pointer and data.
// Operation
// - Erase/write to shared section sets busy flag
// - Busy clears by reenable store or load
// - Control bit 5 always reads zero
// - Reenable plus enable arms store four cycles
// - Reenable refused while programming still runs
// - Reenable write aborts and discards buffer load
// - Lock-set store programs lock bits from low
// - Lock-set clears on completion or timeout
// - Armed load within three cycles returns fuses/locks
// - Page-write store writes buffer to pointer page
// - Page-erase store erases the pointer page
// - Write/erase bits clear on completion or timeout
// - Halting section operation stalls CPU throughout
// - Plain enable store fills one buffer word
// - Enable clears after store or timeout; holds during programming
// - Only five command patterns take effect
// - Pointer splits word/page; page latched at start
// - Load readback uses pointer bits one and zero
// - Buffer erases after write, reenable, reset
// - Interrupt holds while enable bit is clear
// - Interrupt needs local and global enable
`timescale 1ns/1ps
`include "spm_defs.svh"
module self_programming_flash_control #(
   parameter int unsigned PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire logic              CLK_SYS_IN,
   input  wire logic              RESETN_IN,
   input  wire logic              S_AXI_AWVALID_IN,
   output logic                   S_AXI_AWREADY_OUT,
   input  wire logic [`ADDR_W-1:0] S_AXI_AWADDR_IN,
   input  wire logic              S_AXI_WVALID_IN,
   output logic                   S_AXI_WREADY_OUT,
   input  wire logic [31:0]       S_AXI_WDATA_IN,
   input  wire logic [3:0]        S_AXI_WSTRB_IN,
   output logic                   S_AXI_BVALID_OUT,
   input  wire logic              S_AXI_BREADY_IN,
   output logic [1:0]             S_AXI_BRESP_OUT,
   input  wire logic              S_AXI_ARVALID_IN,
   output logic                   S_AXI_ARREADY_OUT,
   input  wire logic [`ADDR_W-1:0] S_AXI_ARADDR_IN,
   output logic                   S_AXI_RVALID_OUT,
   input  wire logic              S_AXI_RREADY_IN,
   output logic [31:0]            S_AXI_RDATA_OUT,
   output logic [1:0]             S_AXI_RRESP_OUT,
   input  spm_pkg::cpu_req_t      CPU_REQ_IN,
   output spm_pkg::lpm_rsp_t      LPM_RSP_OUT,
   input  wire logic              GLOBAL_INT_EN_IN,
   input  wire logic [7:0]        FUSE_LOW_IN,
   input  wire logic [7:0]        FUSE_HIGH_IN,
   input  wire logic [7:0]        FUSE_EXT_IN,
   input  wire logic [`WORD_W-1:0] FLASH_BUF_ADDR_IN,
   output logic [15:0]            FLASH_BUF_DATA_OUT,
   output logic                   FLASH_ERASE_OUT,
   output logic                   FLASH_WRITE_OUT,
   output logic [`PAGE_W-1:0]     FLASH_PAGE_OUT,
   output logic                   RWW_BLOCKED_OUT,
   output logic                   CPU_HALT_OUT,
   output logic                   STORE_READY_IRQ_OUT
);
   spm_pkg::op_state_t state_q, state_d;
   logic             int_en_q, busy_flag_q, reen_q, lock_q, pgwr_q, pger_q, en_q;
   logic [2:0]       arm_cnt_q, lpm_cnt_q;
   logic [`PAGE_W-1:0] page_q;
   logic             rww_op_q, wr_op_q, erase_q, write_q;
   logic [7:0]       lock_bits_q;
   logic             aw_held_q, w_held_q, bvalid_q, rvalid_q, rd_ctrl_q;
   logic [`ADDR_W-1:0] awaddr_q;
   logic [7:0]       wdata_q;
   logic             wlane_q;
   logic [1:0]       bresp_q, rresp_q;
   logic [7:0]       rdata_q;
   spm_pkg::lpm_rsp_t rsp_q;

   // Bus decode
   wire wr_go    = aw_held_q && w_held_q && !bvalid_q;
   wire wr_ctrl  = wr_go && awaddr_q == `OFF_CTRL;
   wire wr_ok    = wr_ctrl || (wr_go && awaddr_q == `OFF_LOCK);
   wire ar_go    = S_AXI_ARVALID_IN && !rvalid_q;
   wire rd_ctrl  = S_AXI_ARADDR_IN == `OFF_CTRL;
   wire rd_ok    = rd_ctrl || S_AXI_ARADDR_IN == `OFF_LOCK;
   wire [4:0] cmd = wdata_q[4:0];
   wire cmd_ok   = cmd == `CMD_REEN || cmd == `CMD_LOCK || cmd == `CMD_PGWR ||
                   cmd == `CMD_PGER || cmd == `CMD_LOAD;
   // Commands are ignored while an erase or write runs
   wire cmd_take = wr_ctrl && wlane_q && cmd_ok && state_q != spm_pkg::ST_PROG;
   wire [7:0] ctrl_val = {int_en_q, busy_flag_q, 1'b0, reen_q, lock_q, pgwr_q, pger_q, en_q};

   // Instruction decode
   wire armed      = state_q == spm_pkg::ST_ARMED;
   wire spm_go     = CPU_REQ_IN.spm && armed;
   wire lpm_go     = CPU_REQ_IN.load_program_instruction && armed && lock_q && lpm_cnt_q != 3'h0;
   wire start_prog = spm_go && (pgwr_q || pger_q);
   wire load_go    = spm_go && !(reen_q || lock_q || pgwr_q || pger_q);
   wire expire     = armed && arm_cnt_q == 3'h1 && !spm_go && !lpm_go;
   wire prog_done;
   wire clr_cmd    = (spm_go && !start_prog) || lpm_go || expire || prog_done;
   wire [`PAGE_W-1:0] page_in = CPU_REQ_IN.z[`PAGE_LSB +: `PAGE_W];
   wire in_rww     = page_in < `HALTING_WRITE_SECTION_FIRST_PAGE;
   // Buffer is wiped on reenable write and after a finished page write
   wire buf_clear  = (cmd_take && cmd == `CMD_REEN) || (prog_done && wr_op_q);
   wire [7:0] lpm_data = CPU_REQ_IN.z[1] ? (CPU_REQ_IN.z[0] ? FUSE_HIGH_IN : FUSE_EXT_IN)
                                         : (CPU_REQ_IN.z[0] ? lock_bits_q : FUSE_LOW_IN);

   always_comb begin
      state_d = state_q;
      case (state_q)
         spm_pkg::ST_IDLE: begin
            if (cmd_take) begin
               state_d = spm_pkg::ST_ARMED;
            end
         end
         spm_pkg::ST_ARMED: begin
            if (start_prog) begin
               state_d = spm_pkg::ST_PROG;
            end else if (cmd_take) begin
               state_d = spm_pkg::ST_ARMED;
            end else if (clr_cmd) begin
               state_d = spm_pkg::ST_IDLE;
            end
         end
         spm_pkg::ST_PROG: begin
            if (prog_done) begin
               state_d = spm_pkg::ST_IDLE;
            end
         end
         default: state_d = spm_pkg::ST_IDLE;
      endcase
   end

   // Control register and arming window
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         state_q   <= spm_pkg::ST_IDLE;
         {int_en_q, reen_q, lock_q, pgwr_q, pger_q, en_q} <= '0;
         arm_cnt_q <= 3'h0;
         lpm_cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         if (wr_ctrl && wlane_q) begin
            int_en_q <= wdata_q[`BIT_INT_EN];
         end
         if (cmd_take) begin
            {reen_q, lock_q, pgwr_q, pger_q, en_q} <= cmd;
            arm_cnt_q <= `ARM_CYCLES;
            lpm_cnt_q <= `LPM_CYCLES;
         end else if (clr_cmd) begin
            {reen_q, lock_q, pgwr_q, pger_q, en_q} <= '0;
         end
         if (!cmd_take && arm_cnt_q != 3'h0) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
         end
         if (!cmd_take && lpm_cnt_q != 3'h0) begin
            lpm_cnt_q <= lpm_cnt_q - 3'h1;
         end
      end
   end

   // Section busy flag; a start and a clear cannot meet in one cycle
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         busy_flag_q <= 1'b0;
      end else if (start_prog && in_rww) begin
         busy_flag_q <= 1'b1;
      end else if (load_go || (spm_go && reen_q)) begin
         busy_flag_q <= 1'b0;
      end
   end

   // Operation latch and flash strobes
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         page_q   <= '0;
         rww_op_q <= 1'b0;
         wr_op_q  <= 1'b0;
         erase_q  <= 1'b0;
         write_q  <= 1'b0;
      end else begin
         erase_q <= start_prog && pger_q;
         write_q <= start_prog && pgwr_q;
         if (start_prog) begin
            page_q   <= page_in;
            rww_op_q <= in_rww;
            wr_op_q  <= pgwr_q;
         end
      end
   end

   // Lock byte: bits only ever go from unprogrammed to programmed
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         lock_bits_q <= `LOCK_RESET;
      end else if (spm_go && lock_q) begin
         lock_bits_q[5:2] <= lock_bits_q[5:2] & CPU_REQ_IN.r0[5:2];
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= lpm_go;
         if (lpm_go) begin
            rsp_q.data <= lpm_data;
         end
      end
   end

   // AXI4-Lite write side; address and data may arrive in either order
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 8'h00;
         wlane_q   <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_held_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA_IN[7:0];
            wlane_q  <= S_AXI_WSTRB_IN[0];
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (S_AXI_BREADY_IN) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side; lock byte at its own offset is read-only
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         rvalid_q  <= 1'b0;
         rdata_q   <= 8'h00;
         rresp_q   <= `RESP_OKAY;
         rd_ctrl_q <= 1'b0;
      end else if (ar_go) begin
         rvalid_q  <= 1'b1;
         rd_ctrl_q <= rd_ctrl;
         rdata_q   <= rd_ctrl ? ctrl_val : (rd_ok ? lock_bits_q : 8'h00);
         rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RREADY_IN) begin
         rvalid_q <= 1'b0;
      end
   end

   page_buffer_mem u_buf (
      .clk_in    (CLK_SYS_IN),
      .resetn_in (RESETN_IN),
      .clear_in  (buf_clear),
      .we_in     (load_go),
      .waddr_in  (CPU_REQ_IN.z[`WORD_LSB +: `WORD_W]),
      .wdata_in  ({CPU_REQ_IN.r1, CPU_REQ_IN.r0}),
      .raddr_in  (FLASH_BUF_ADDR_IN),
      .rdata_out (FLASH_BUF_DATA_OUT)
   );

   prog_timer u_timer (
      .clk_in    (CLK_SYS_IN),
      .resetn_in (RESETN_IN),
      .start_in  (start_prog),
      .count_in  (`TIMER_W'(PROG_CYCLES)),
      .done_out  (prog_done)
   );

   assign S_AXI_AWREADY_OUT   = !aw_held_q && !bvalid_q;
   assign S_AXI_WREADY_OUT    = !w_held_q && !bvalid_q;
   assign S_AXI_BVALID_OUT    = bvalid_q;
   assign S_AXI_BRESP_OUT     = bresp_q;
   assign S_AXI_ARREADY_OUT   = !rvalid_q;
   assign S_AXI_RVALID_OUT    = rvalid_q;
   assign S_AXI_RDATA_OUT     = {24'h00_0000, rdata_q};
   assign S_AXI_RRESP_OUT     = rresp_q;
   assign LPM_RSP_OUT         = rsp_q;
   assign FLASH_ERASE_OUT     = erase_q;
   assign FLASH_WRITE_OUT     = write_q;
   assign FLASH_PAGE_OUT      = page_q;
   assign RWW_BLOCKED_OUT     = busy_flag_q;
   assign CPU_HALT_OUT        = state_q == spm_pkg::ST_PROG && !rww_op_q;
   assign STORE_READY_IRQ_OUT = int_en_q && GLOBAL_INT_EN_IN && !en_q;

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESETN_IN);

   // A control write in the last armed cycle re-arms, so it is left out here
   a_arm_expiry_clears: assert property (expire && !cmd_take |=> !en_q && !lock_q && !pgwr_q)
      else $error("arming window did not close after four cycles");
   a_refuse_while_prog: assert property (state_q == spm_pkg::ST_PROG && wr_ctrl && !prog_done
      |=> en_q && !reen_q)
      else $error("command accepted while programming");
   a_busy_on_rww_start: assert property (start_prog && in_rww |=> busy_flag_q [*3])
      else $error("section busy flag not set");
   a_busy_clear_load: assert property (load_go |=> !RWW_BLOCKED_OUT)
      else $error("page load did not clear busy flag");
   a_reserved_bit_zero: assert property (rvalid_q && rd_ctrl_q |-> !S_AXI_RDATA_OUT[`BIT_RSVD])
      else $error("reserved bit read as one");
   a_enable_held_prog: assert property (start_prog |=> (en_q && state_q == spm_pkg::ST_PROG) [*8])
      else $error("enable dropped during programming");
   a_halt_halting_write_section_prog: assert property (start_prog && !in_rww |=> CPU_HALT_OUT [*4])
      else $error("cpu not halted for halting section");
   a_irq_after_done: assert property ($fell(en_q) && int_en_q && GLOBAL_INT_EN_IN |-> STORE_READY_IRQ_OUT)
      else $error("store ready interrupt missing");
   a_lpm_reply_data: assert property (lpm_go |=> LPM_RSP_OUT.valid && LPM_RSP_OUT.data == $past(lpm_data))
      else $error("readback reply wrong");
   a_lock_only_program: assert property (spm_go && lock_q |=> (lock_bits_q & ~$past(lock_bits_q)) == 8'h00)
      else $error("lock bit went unprogrammed");
   a_bad_cmd_ignored: assert property (wr_ctrl && !cmd_ok && state_q == spm_pkg::ST_IDLE
      |=> state_q == spm_pkg::ST_IDLE)
      else $error("invalid pattern took effect");
   a_lock_done_clears: assert property (spm_go && lock_q && !cmd_take |=> !lock_q && !en_q)
      else $error("lock set bit stayed after store");
   a_strobe_one_cycle: assert property (FLASH_ERASE_OUT || FLASH_WRITE_OUT |=> !FLASH_ERASE_OUT && !FLASH_WRITE_OUT)
      else $error("flash strobe longer than one cycle");
   a_prog_end_clears: assert property (prog_done |=> !en_q && !pgwr_q && !pger_q && !CPU_HALT_OUT)
      else $error("command bits stayed after programming");
   a_reen_clears_busy: assert property (spm_go && reen_q |=> !busy_flag_q)
      else $error("reenable store left section busy");
   a_page_latched: assert property (start_prog |=> FLASH_PAGE_OUT == $past(page_in))
      else $error("page index not latched at start");

   c_page_load: cover property (load_go);
   c_page_write: cover property (start_prog && pgwr_q ##[1:200] prog_done);
   c_page_erase: cover property (start_prog && pger_q);
   c_reenable: cover property (spm_go && reen_q);
   c_lock_read: cover property (lpm_go);
endmodule

// file: dv/cpu_core_model.sv
// CPU core model: one-cycle store and load instruction strobes.
// Assumes callers start a request right after a rising clock edge.
`timescale 1ns/1ps
module cpu_core_model (
   input  wire logic         clk_in,
   output spm_pkg::cpu_req_t req_out
);
   initial begin
      req_out = '0;
   end
   // Pointer and data flip once released, so stale values never look valid
   task automatic issue(input logic st, input logic [15:0] z, input logic [7:0] r0, input logic [7:0] r1);
      req_out <= '{spm: st, load_program_instruction: !st, z: z, r0: r0, r1: r1};
      @(posedge clk_in);
      req_out <= '{spm: 1'b0, load_program_instruction: 1'b0, z: ~z, r0: ~r0, r1: ~r1};
   endtask
endmodule

// file: dv/self_programming_flash_control_tb.sv
// Testbench for the self-programming flash controller.
// Assumes the package, design files and the CPU core model are compiled first.
`timescale 1ns/1ps
module self_programming_flash_control_tb;
   localparam int PROG  = 20;
   localparam int LIMIT = 4000;
   localparam logic [24:0] BAD_CMDS  = {5'h1F, 5'h07, 5'h10, 5'h02, 5'h19};
   localparam logic [19:0] GOOD_CMDS = {5'h01, 5'h09, 5'h05, 5'h03};
   logic              clk = 0, rstn = 0, gie = 0;
   logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]        awaddr = 8'h00, araddr = 8'h00, fl = 8'h00, fh = 8'h00, fe = 8'h00;
   logic [31:0]       wdata = 32'h0000_0000;
   logic [5:0]        baddr = 6'h00;
   logic [15:0]       rnd = 16'hD313;
   logic [15:0]       d;
   wire               awready, wready, bvalid, arready, rvalid, erase, write, blocked, halt, irq;
   wire [1:0]         bresp, rresp;
   wire [31:0]        rdata;
   wire [15:0]        bdata;
   wire [8:0]         page;
   spm_pkg::cpu_req_t req;
   spm_pkg::lpm_rsp_t rsp;
   logic [33:0]       notes[$];
   int                err_total = 0, n_checks = 0, cyc = 0;

   self_programming_flash_control #(.PROG_CYCLES(PROG)) self_programming_flash_control_i (
      .CLK_SYS_IN(clk), .RESETN_IN(rstn),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
      .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_ARADDR_IN(araddr),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .CPU_REQ_IN(req), .LPM_RSP_OUT(rsp), .GLOBAL_INT_EN_IN(gie),
      .FUSE_LOW_IN(fl), .FUSE_HIGH_IN(fh), .FUSE_EXT_IN(fe),
      .FLASH_BUF_ADDR_IN(baddr), .FLASH_BUF_DATA_OUT(bdata), .FLASH_ERASE_OUT(erase),
      .FLASH_WRITE_OUT(write), .FLASH_PAGE_OUT(page), .RWW_BLOCKED_OUT(blocked),
      .CPU_HALT_OUT(halt), .STORE_READY_IRQ_OUT(irq));
   cpu_core_model cpu_core_model_i (.clk_in(clk), .req_out(req));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [33:0] ok8(input logic [7:0] v);
      return {26'h000_0000, v};
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] resp);
      logic ta, tw, tb;
      notes.push_back({resp, 32'h0000_0000});
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; awaddr <= a; wdata <= {24'h00_0000, v};
      do begin
         @(negedge clk);
         ta = awvalid & awready; tw = wvalid & wready; tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
      // Ready left high so a following call never reassigns it in one step
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      logic ta, tr;
      notes.push_back(exp);
      arvalid <= 1'b1; rready <= 1'b1; araddr <= a;
      do begin
         @(negedge clk);
         ta = arvalid & arready; tr = rvalid;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask
   task automatic load(input logic [5:0] w, input logic [15:0] v);
      wr(8'h00, 8'h81, 2'h0);
      cpu_core_model_i.issue(1'b1, {9'h000, w, 1'b1}, v[7:0], v[15:8]);
   endtask
   task automatic buf_is(input logic [5:0] w, input logic [15:0] v);
      baddr <= w;
      @(posedge clk);
      @(negedge clk);
      chk(bdata, v, "buffer word");
      @(posedge clk);
   endtask
   task automatic prog(input logic [4:0] cmd, input logic [8:0] pg, input logic hlt);
      wr(8'h00, {3'b100, cmd}, 2'h0);
      cpu_core_model_i.issue(1'b1, {pg, 7'h00}, rnd[7:0], rnd[15:8]);
      @(negedge clk);
      chk({erase, write, page, halt, blocked}, {cmd[1], cmd[2], pg, hlt, !hlt}, "start");
      chk(irq, 1'b0, "irq while busy");
      @(posedge clk);
      rd(8'h00, ok8({1'b1, !hlt, 1'b0, cmd}));
      wr(8'h00, 8'h91, 2'h0);
      rd(8'h00, ok8({1'b1, !hlt, 1'b0, cmd}));
      tick(PROG + 2);
      @(negedge clk);
      chk({halt, blocked, page}, {1'b0, !hlt, pg}, "end");
      @(posedge clk);
      rd(8'h00, ok8({1'b1, !hlt, 6'h00}));
   endtask

   // Each answer on the bus or the load port takes the oldest note
   always @(negedge clk) begin
      if ((bvalid & bready) | (rvalid & rready) | rsp.valid) begin
         if (notes.size() == 0) begin
            chk(34'h0_0000_0000, 34'h0_0000_0001, "answer without note");
         end else begin
            chk(rvalid ? {rresp, rdata} : (bvalid ? {bresp, 32'h0000_0000} : ok8(rsp.data)),
                notes.pop_front(), "answer");
         end
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      tick(2);
      rstn <= 1'b1;
      gie <= 1'b1;
      fl <= rnd[7:0];
      fh <= rnd[15:8];
      fe <= ~rnd[7:0];
      rd(8'h00, ok8(8'h00));
      rd(8'h04, ok8(8'hFF));
      rd(8'h08, {2'h2, 32'h0000_0000});
      wr(8'h08, 8'h55, 2'h2);
      @(negedge clk);
      chk(irq, 1'b0, "irq after reset");
      @(posedge clk);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, {3'b111, BAD_CMDS[5*i +: 5]}, 2'h0);
         rd(8'h00, ok8(8'h80));
      end
      @(negedge clk);
      chk(irq, 1'b1, "irq enabled");
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      chk(irq, 1'b0, "irq global off");
      @(posedge clk);
      gie <= 1'b1;
      $display("test patterns done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {3'b100, GOOD_CMDS[5*i +: 5]}, 2'h0);
         tick(6);
         cpu_core_model_i.issue(1'b1, 16'h0280, 8'h00, 8'h00);
         @(negedge clk);
         chk({erase, write, blocked}, 3'b000, "late store");
         @(posedge clk);
         rd(8'h00, ok8(8'h80));
      end
      $display("test timeout done");
      wr(8'h00, 8'h89, 2'h0);
      cpu_core_model_i.issue(1'b1, rnd, 8'hEB, rnd[15:8]);
      rd(8'h04, ok8(8'hEB));
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 8'h89, 2'h0);
         notes.push_back(ok8(i == 0 ? fl : (i == 1 ? 8'hEB : (i == 2 ? fe : fh))));
         cpu_core_model_i.issue(1'b0, {14'h0000, i[1:0]}, 8'h00, 8'h00);
         rd(8'h00, ok8(8'h80));
      end
      $display("test lock done");
      rnd = lfsr(rnd);
      d = rnd;
      load(6'h03, d);
      buf_is(6'h03, d);
      rd(8'h00, ok8(8'h80));
      prog(5'h03, 9'h005, 1'b0);
      wr(8'h00, 8'h91, 2'h0);
      cpu_core_model_i.issue(1'b1, rnd, 8'h00, 8'h00);
      @(negedge clk);
      chk(blocked, 1'b0, "busy cleared");
      @(posedge clk);
      buf_is(6'h03, 16'hFFFF);
      rd(8'h00, ok8(8'h80));
      $display("test erase done");
      rnd = lfsr(rnd);
      load(6'h02, rnd);
      prog(5'h05, 9'h1C3, 1'b1);
      buf_is(6'h02, 16'hFFFF);
      $display("test write done");
      prog(5'h03, 9'h007, 1'b0);
      load(6'h04, rnd);
      @(negedge clk);
      chk(blocked, 1'b0, "busy cleared by load");
      @(posedge clk);
      $display("test load clear done");
      load(6'h05, rnd);
      rstn <= 1'b0;
      tick(2);
      rstn <= 1'b1;
      buf_is(6'h05, 16'hFFFF);
      rd(8'h00, ok8(8'h00));
      $display("test reset again done");
      tick(4);
      give_verdict();
   end
endmodule
